// ---- adcctl_regs.vh ----
// Summary of operation
// - per-conversion dma enable set: request pulse on every finished conversion
// - sequence-done dma enable set: request pulse when a sequence completes
// - all-channel watch enable set: watchdog checks every converted channel
// - four-bit field picks the single channel the watchdog monitors
// - four-bit field picks converted channel: 0-12 inputs, 13 vdda/3, 14 temp, 15 ref
// - alignment clear: twelve-bit result right justified in bits 11:0
// - alignment set: twelve-bit result left justified in bits 15:4
// - policy clear: new result overwrites unread older result
// - policy set: outside sequence mode, new result dropped while an unread result exists
// - writing one to accumulator clear zeroes the sum; bit reads zero
// - accumulation enable set: results added into the accumulated value
// - multiple-conversion modes perform count field plus one conversions
// - count applies to single multiple mode 001 and sequence multiple mode 101
// - watchdog compares against twelve-bit high (reset all ones) and low thresholds
`ifndef ADCCTL_REGS_VH
`define ADCCTL_REGS_VH
`define ADCCTL_CTRL1_ADDR    12'h004
`define ADCCTL_CTRL2_ADDR    12'h010
`define ADCCTL_HTHR_ADDR     12'h014
`define ADCCTL_LTHR_ADDR     12'h018
`define ADCCTL_RESULT_ADDR   12'h020
`define ADCCTL_ACCUM_ADDR    12'h024
`define ADCCTL_STAT_ADDR     12'h028
`define ADCCTL_IRQEN_ADDR    12'h02c
`define ADCCTL_IRQCLR_ADDR   12'h030
`define ADCCTL_CTRL1_MASK    32'h0000ef6f
`define ADCCTL_CTRL2_MASK    32'h000001ff
`define ADCCTL_HTHR_RESET    12'hfff
`define ADCCTL_LTHR_RESET    12'h000
`define ADCCTL_B_DMA_CONV    15
`define ADCCTL_B_DMA_SEQ     14
`define ADCCTL_B_WATCH_ALL   13
`define ADCCTL_B_ALIGN       6
`define ADCCTL_B_DISCARD     5
`define ADCCTL_B_ACC_CLR     9
`define ADCCTL_B_ACC_EN      8
`define ADCCTL_MODE_SGL_MULT 3'h1
`define ADCCTL_MODE_SEQ_MULT 3'h5
`define ADCCTL_ST_CONV       0
`define ADCCTL_ST_SEQ        1
`define ADCCTL_ST_WATCH      2
`define ADCCTL_ST_OVR        3
`define ADCCTL_ST_WIDTH      4
`endif

// ---- adcctl_repeat.v ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// conversion repeat counter
// ------------------------------------------------------------
module adcctl_repeat #(
  parameter CW = 8
) (
  input  wire          clock_in,
  input  wire          rst_b_in,
  input  wire          multi_mode_in,
  input  wire [CW-1:0] count_in,
  input  wire          start_in,
  input  wire          done_in,
  output wire          busy_out,
  output wire          again_out,
  output wire          last_out
);
  reg  [CW:0] left_reg;
  reg  [CW:0] left_next;
  assign busy_out  = (left_reg != {(CW+1){1'b0}});
  assign last_out  = done_in && (left_reg == {{CW{1'b0}}, 1'b1});
  assign again_out = done_in && (left_reg > {{CW{1'b0}}, 1'b1});
  always @*
  begin
    left_next = left_reg;
    if (start_in && !busy_out)
      left_next = multi_mode_in ? ({1'b0, count_in} + {{CW{1'b0}}, 1'b1}) : {{CW{1'b0}}, 1'b1};
    else if (done_in && busy_out)
      left_next = left_reg - {{CW{1'b0}}, 1'b1};
  end
  always @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      left_reg <= {(CW+1){1'b0}};
    else
      left_reg <= left_next;
  end
endmodule // adcctl_repeat
`default_nettype wire

// ---- adcctl_top.v ----
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "adcctl_regs.vh"
module adcctl_top #(
  parameter RW  = 12,
  parameter AW  = 32
) (
  input  wire        clock_in,
  input  wire        rst_b_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output wire        pready_out,
  output wire        pslverr_out,
  input  wire [2:0]  op_mode_in,
  input  wire        start_in,
  input  wire        conv_done_in,
  input  wire [3:0]  conv_channel_in,
  input  wire [RW-1:0] conv_data_in,
  input  wire        seq_mode_in,
  input  wire        seq_last_in,
  output reg  [3:0]  convert_channel_sel_out,
  output reg  [3:0]  watch_channel_sel_out,
  output reg         convert_again_out,
  output reg         dma_req_conv_out,
  output reg         dma_req_seq_out,
  output reg         watch_alarm_out,
  output reg  [15:0] result_out,
  output reg         result_unread_out,
  output wire        irq_out
);
// ------------------------------------------------------------
// reset release
// ------------------------------------------------------------
  reg        rst_meta_reg;
  reg        rst_sync_reg;
  wire       rst_b;
  always @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_b = rst_sync_reg;
// ------------------------------------------------------------
// apb decode
// ------------------------------------------------------------
  wire        wr_en   = psel_in && penable_in && pwrite_in;
  wire        rd_en   = psel_in && penable_in && !pwrite_in;
  wire        hit_c1  = (paddr_in == `ADCCTL_CTRL1_ADDR);
  wire        hit_c2  = (paddr_in == `ADCCTL_CTRL2_ADDR);
  wire        hit_ht  = (paddr_in == `ADCCTL_HTHR_ADDR);
  wire        hit_lt  = (paddr_in == `ADCCTL_LTHR_ADDR);
  wire        hit_res = (paddr_in == `ADCCTL_RESULT_ADDR);
  wire        hit_acc = (paddr_in == `ADCCTL_ACCUM_ADDR);
  wire        hit_st  = (paddr_in == `ADCCTL_STAT_ADDR);
  wire        hit_ie  = (paddr_in == `ADCCTL_IRQEN_ADDR);
  wire        hit_ic  = (paddr_in == `ADCCTL_IRQCLR_ADDR);
  wire        mapped  = hit_c1 | hit_c2 | hit_ht | hit_lt | hit_res | hit_acc | hit_st | hit_ie | hit_ic;
  // zero wait states keeps the master simple
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in && penable_in && !mapped;
// ------------------------------------------------------------
// registers
// ------------------------------------------------------------
  reg  [31:0] ctrl1_reg;
  reg  [8:0]  ctrl2_reg;
  reg  [11:0] hthr_reg;
  reg  [11:0] lthr_reg;
  reg  [AW-1:0] accum_reg;
  reg  [AW-1:0] accum_next;
  reg  [`ADCCTL_ST_WIDTH-1:0] stat_reg;
  reg  [`ADCCTL_ST_WIDTH-1:0] stat_next;
  reg  [`ADCCTL_ST_WIDTH-1:0] irqen_reg;
  wire        acc_clear = wr_en && hit_c2 && pwdata_in[`ADCCTL_B_ACC_CLR];
  always @(posedge clock_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl1_reg <= 32'h00000000;
      ctrl2_reg <= 9'h000;
      hthr_reg  <= `ADCCTL_HTHR_RESET;
      lthr_reg  <= `ADCCTL_LTHR_RESET;
      irqen_reg <= {`ADCCTL_ST_WIDTH{1'b0}};
    end
    else if (wr_en)
    begin
      // reserved bits held at zero so stray writes cannot leak into them
      if (hit_c1)
        ctrl1_reg <= pwdata_in & `ADCCTL_CTRL1_MASK;
      else if (hit_c2)
        ctrl2_reg <= pwdata_in[8:0];
      else if (hit_ht)
        hthr_reg <= pwdata_in[11:0];
      else if (hit_lt)
        lthr_reg <= pwdata_in[11:0];
      else if (hit_ie)
        irqen_reg <= pwdata_in[`ADCCTL_ST_WIDTH-1:0];
    end
  end
  wire        dma_conv_en  = ctrl1_reg[`ADCCTL_B_DMA_CONV];
  wire        dma_seq_en   = ctrl1_reg[`ADCCTL_B_DMA_SEQ];
  wire        watch_all_en = ctrl1_reg[`ADCCTL_B_WATCH_ALL];
  wire        align_left   = ctrl1_reg[`ADCCTL_B_ALIGN];
  wire        keep_old     = ctrl1_reg[`ADCCTL_B_DISCARD];
  wire        accum_en     = ctrl2_reg[`ADCCTL_B_ACC_EN];
// ------------------------------------------------------------
// conversion sequencing
// ------------------------------------------------------------
  wire        multi_mode = (op_mode_in == `ADCCTL_MODE_SGL_MULT) || (op_mode_in == `ADCCTL_MODE_SEQ_MULT);
  wire        rep_again;
  wire        rep_last;
  adcctl_repeat #(
    .CW (8)
  ) u_repeat (
    .clock_in      (clock_in),
    .rst_b_in      (rst_b),
    .multi_mode_in (multi_mode),
    .count_in      (ctrl2_reg[7:0]),
    .start_in      (start_in),
    .done_in       (conv_done_in),
    .busy_out      (),
    .again_out     (rep_again),
    .last_out      (rep_last)
  );
  wire        seq_done = conv_done_in && (seq_mode_in ? (seq_last_in && (!multi_mode || rep_last)) : 1'b0);
// ------------------------------------------------------------
// result handling
// ------------------------------------------------------------
  wire [15:0] aligned = align_left ? {conv_data_in, 4'h0} : {4'h0, conv_data_in};
  wire        store   = conv_done_in && !(keep_old && result_unread_out && !seq_mode_in);
  wire        res_read = rd_en && hit_res;
  wire        watched = watch_all_en || (conv_channel_in == watch_channel_sel_out);
  wire        out_win = (conv_data_in > hthr_reg) || (conv_data_in < lthr_reg);
  wire        alarm   = conv_done_in && watched && out_win;
  wire        overrun = conv_done_in && result_unread_out;
  always @*
  begin
    accum_next = accum_reg;
    if (acc_clear)
      accum_next = {AW{1'b0}};
    if (accum_en && conv_done_in)
      accum_next = accum_next + {{(AW-RW){1'b0}}, conv_data_in};
  end
  always @*
  begin
    // events win over a same-cycle clear
    stat_next = stat_reg;
    if (wr_en && hit_ic)
      stat_next = stat_reg & ~pwdata_in[`ADCCTL_ST_WIDTH-1:0];
    if (conv_done_in)
      stat_next[`ADCCTL_ST_CONV] = 1'b1;
    if (seq_done)
      stat_next[`ADCCTL_ST_SEQ] = 1'b1;
    if (alarm)
      stat_next[`ADCCTL_ST_WATCH] = 1'b1;
    if (overrun)
      stat_next[`ADCCTL_ST_OVR] = 1'b1;
  end
  always @(posedge clock_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      accum_reg               <= {AW{1'b0}};
      stat_reg                <= {`ADCCTL_ST_WIDTH{1'b0}};
      result_out              <= 16'h0000;
      result_unread_out       <= 1'b0;
      dma_req_conv_out        <= 1'b0;
      dma_req_seq_out         <= 1'b0;
      watch_alarm_out         <= 1'b0;
      convert_again_out       <= 1'b0;
      convert_channel_sel_out <= 4'h0;
      watch_channel_sel_out   <= 4'h0;
    end
    else
    begin
      accum_reg               <= accum_next;
      stat_reg                <= stat_next;
      convert_channel_sel_out <= ctrl1_reg[3:0];
      watch_channel_sel_out   <= ctrl1_reg[11:8];
      dma_req_conv_out        <= conv_done_in && dma_conv_en;
      dma_req_seq_out         <= seq_done && dma_seq_en;
      watch_alarm_out         <= alarm;
      convert_again_out       <= rep_again;
      if (store)
        result_out <= aligned;
      if (store)
        result_unread_out <= 1'b1;
      else if (res_read)
        result_unread_out <= 1'b0;
    end
  end
  assign irq_out = |(stat_reg & irqen_reg);
// ------------------------------------------------------------
// read mux
// ------------------------------------------------------------
  always @*
  begin
    prdata_out = 32'h00000000;
    if (rd_en)
    begin
      if (hit_c1)
        prdata_out = ctrl1_reg;
      else if (hit_c2)
        prdata_out = {23'h000000, ctrl2_reg};
      else if (hit_ht)
        prdata_out = {20'h00000, hthr_reg};
      else if (hit_lt)
        prdata_out = {20'h00000, lthr_reg};
      else if (hit_res)
        prdata_out = {16'h0000, result_out};
      else if (hit_acc)
        prdata_out = accum_reg;
      else if (hit_st)
        prdata_out = {28'h0000000, stat_reg};
      else if (hit_ie)
        prdata_out = {28'h0000000, irqen_reg};
    end
  end
endmodule // adcctl_top
`default_nettype wire

// ---- adcctl_props.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port checker
// ----------------------------------------
module adcctl_props #(
  parameter RW = 12
) (
  input wire logic          clock_in,
  input wire logic          rst_b_in,
  input wire logic          psel_in,
  input wire logic          penable_in,
  input wire logic          conv_done_in,
  input wire logic          seq_last_in,
  input wire logic [RW-1:0] conv_data_in,
  input wire logic [31:0]   prdata_out,
  input wire logic          pready_out,
  input wire logic          pslverr_out,
  input wire logic          convert_again_out,
  input wire logic          dma_req_conv_out,
  input wire logic          dma_req_seq_out,
  input wire logic          watch_alarm_out,
  input wire logic [15:0]   result_out,
  input wire logic          result_unread_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_b_in);
  chk_ready_high: assert property (pready_out) else $error("pready low");
  chk_idle_rdata: assert property (!(psel_in && penable_in) |-> prdata_out == 32'h0) else $error("prdata idle");
  chk_err_access: assert property (pslverr_out |-> psel_in && penable_in) else $error("pslverr idle");
  chk_dma_cause: assert property (dma_req_conv_out |-> $past(conv_done_in)) else $error("dma conv");
  chk_seq_cause: assert property (dma_req_seq_out |-> $past(conv_done_in && seq_last_in)) else $error("dma seq");
  chk_alarm_cause: assert property (watch_alarm_out |-> $past(conv_done_in)) else $error("alarm");
  chk_again_cause: assert property (convert_again_out |-> $past(conv_done_in)) else $error("again");
  chk_unread_set: assert property ($rose(result_unread_out) |-> $past(conv_done_in)) else $error("unread");
  // a stored word is the last sample in one of the two placements
  chk_result_align: assert property (!$stable(result_out) |-> result_out == {4'h0, $past(conv_data_in)}
    || result_out == {$past(conv_data_in), 4'h0}) else $error("result align");
endmodule // adcctl_props
bind adcctl_top adcctl_props #(.RW(RW)) adcctl_props_inst (.clock_in, .rst_b_in, .psel_in, .penable_in,
  .conv_done_in, .seq_last_in, .conv_data_in, .prdata_out, .pready_out, .pslverr_out, .convert_again_out,
  .dma_req_conv_out, .dma_req_seq_out, .watch_alarm_out, .result_out, .result_unread_out);
`default_nettype wire

// ---- adcctl_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// converter core stand-in
// ----------------------------------------
module adcctl_core_model (
  input  wire logic        clock_in,
  input  wire logic [3:0]  chan_sel_in,
  output var  logic        done_out,
  output var  logic [3:0]  chan_out,
  output var  logic [11:0] data_out,
  output var  logic        last_out
);
  initial
  begin
    done_out = 1'b0;
    chan_out = 4'h0;
    data_out = 12'h0;
    last_out = 1'b0;
  end
  // lines invert after the pulse so stale data never passes for valid
  task automatic convert(input logic [11:0] d, input logic last, input int slow);
    repeat (slow + 1) @(posedge clock_in);
    done_out <= 1'b1;
    chan_out <= chan_sel_in;
    data_out <= d;
    last_out <= last;
    @(posedge clock_in);
    done_out <= 1'b0;
    chan_out <= ~chan_sel_in;
    data_out <= ~d;
    last_out <= ~last;
  endtask
endmodule // adcctl_core_model
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "adcctl_regs.vh"
module tb_top;
  logic        clock_in = 1'b0, rst_b_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic        start_in = 1'b0, seq_mode_in = 1'b0, pready_out, pslverr_out, conv_done_in, seq_last_in, err;
  logic        convert_again_out, dma_req_conv_out, dma_req_seq_out, watch_alarm_out, result_unread_out, irq_out;
  logic [2:0]  op_mode_in = 3'h0;
  logic [3:0]  conv_channel_in, convert_channel_sel_out, watch_channel_sel_out;
  logic [11:0] paddr_in = 12'h0, conv_data_in;
  logic [15:0] result_out;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rdv;
  int          err_count = 0, n_compared = 0;
  adcctl_top adcctl_top_inst (.*);
  adcctl_core_model adcctl_core_model_inst (.clock_in(clock_in), .chan_sel_in(convert_channel_sel_out),
    .done_out(conv_done_in), .chan_out(conv_channel_in), .data_out(conv_data_in), .last_out(seq_last_in));
  always #10 clock_in = ~clock_in;
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge clock_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1'b1;
    do @(posedge clock_in); while (pready_out !== 1'b1);
    rdv = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    #1;
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(string nm, logic [11:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdv);
  endtask
  task automatic conv(logic [11:0] d, logic l, int s);
    adcctl_core_model_inst.convert(d, l, s);
    #1;
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    #200000;
    err_count++;
    test_done();
  end
  initial
  begin
    logic [31:0] wc[5] = '{32'h0303, 32'h0503, 32'h2503, 32'h0303, 32'h0303};
    logic [11:0] wd[5] = '{12'h900, 12'h900, 12'h900, 12'h050, 12'h400};
    logic        we[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    repeat (3) @(posedge clock_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    rdc("ctrl1", `ADCCTL_CTRL1_ADDR, 32'h0);
    rdc("ctrl2", `ADCCTL_CTRL2_ADDR, 32'h0);
    rdc("hthr", `ADCCTL_HTHR_ADDR, 32'hfff);
    rdc("lthr", `ADCCTL_LTHR_ADDR, 32'h0);
    for (int i = 0; i < 16; i++)
    begin
      wr(`ADCCTL_CTRL1_ADDR, i * 257);
      // channel selects are registered copies of ctrl1, one edge behind the write
      @(posedge clock_in);
      #1;
      chk("csel", i, convert_channel_sel_out);
      chk("wsel", i, watch_channel_sel_out);
    end
    wr(`ADCCTL_CTRL1_ADDR, 32'h8003);
    conv(12'habc, 1'b0, 0);
    chk("res", 32'h0abc, result_out);
    chk("dreq", 1, dma_req_conv_out);
    rdc("rres", `ADCCTL_RESULT_ADDR, 32'habc);
    wr(`ADCCTL_CTRL1_ADDR, 32'h0043);
    conv(12'h123, 1'b0, 2);
    chk("res", 32'h1230, result_out);
    chk("dreq", 0, dma_req_conv_out);
    conv(12'h456, 1'b0, 0);
    chk("res", 32'h4560, result_out);
    wr(`ADCCTL_CTRL1_ADDR, 32'h0023);
    conv(12'h789, 1'b0, 0);
    chk("res", 32'h4560, result_out);
    rdc("rres", `ADCCTL_RESULT_ADDR, 32'h4560);
    chk("unread", 0, result_unread_out);
    conv(12'h789, 1'b0, 0);
    chk("res", 32'h0789, result_out);
    wr(`ADCCTL_IRQEN_ADDR, 32'h1);
    chk("irq", 1, irq_out);
    wr(`ADCCTL_IRQCLR_ADDR, 32'hf);
    chk("irq", 0, irq_out);
    rdc("clr", `ADCCTL_IRQCLR_ADDR, 32'h0);
    conv(12'h001, 1'b0, 0);
    chk("irq", 1, irq_out);
    rdc("stat", `ADCCTL_STAT_ADDR, 32'h9);
    wr(`ADCCTL_IRQEN_ADDR, 32'h0);
    chk("irq", 0, irq_out);
    @(posedge clock_in) seq_mode_in <= 1'b1;
    wr(`ADCCTL_CTRL1_ADDR, 32'h4003);
    conv(12'h010, 1'b1, 0);
    chk("dseq", 1, dma_req_seq_out);
    wr(`ADCCTL_CTRL1_ADDR, 32'h0003);
    conv(12'h010, 1'b1, 0);
    chk("dseq", 0, dma_req_seq_out);
    wr(`ADCCTL_HTHR_ADDR, 32'h800);
    wr(`ADCCTL_LTHR_ADDR, 32'h100);
    for (int k = 0; k < 5; k++)
    begin
      wr(`ADCCTL_CTRL1_ADDR, wc[k]);
      conv(wd[k], 1'b0, k % 2);
      chk("alarm", we[k], watch_alarm_out);
    end
    wr(`ADCCTL_CTRL2_ADDR, 32'h300);
    conv(12'h005, 1'b0, 0);
    conv(12'h007, 1'b0, 1);
    rdc("acc", `ADCCTL_ACCUM_ADDR, 32'hc);
    rdc("ctrl2", `ADCCTL_CTRL2_ADDR, 32'h100);
    wr(`ADCCTL_CTRL2_ADDR, 32'h200);
    rdc("acc", `ADCCTL_ACCUM_ADDR, 32'h0);
    conv(12'h009, 1'b0, 0);
    rdc("acc", `ADCCTL_ACCUM_ADDR, 32'h0);
    wr(`ADCCTL_CTRL2_ADDR, 32'h2);
    for (int j = 0; j < 3; j++)
    begin
      @(posedge clock_in);
      op_mode_in <= (j == 0) ? `ADCCTL_MODE_SGL_MULT : (j == 1) ? `ADCCTL_MODE_SEQ_MULT : 3'h0;
      seq_mode_in <= (j == 1);
      @(posedge clock_in) start_in <= 1'b1;
      @(posedge clock_in) start_in <= 1'b0;
      for (int k = 0; k < 3; k++)
      begin
        conv(12'h001, j == 1, 0);
        chk("again", j < 2 && k < 2, convert_again_out);
      end
    end
    apb(1'b0, 12'h0fc, 32'h0);
    chk("perr", 1, err);
    chk("pdat", 0, rdv);
    test_done();
  end
endmodule // tb_top
`default_nettype wire
